/* src/wrc_pkg.sv */
/*
 Package for the watchdog and reset-source controller: register offsets,
 field positions, values after reset, legal codes and delay counts.
 Assumes a 50 MHz system clock; every delay is derived from that rate.
*/
package wrc_pkg;

    // System clock period
    localparam int CLK_PERIOD_NS = 20;

    // Register offsets on the plain register port
    localparam logic [2:0] OFS_WDT_CTRL = 3'h0;
    localparam logic [2:0] OFS_RST_FLAGS = 3'h1;
    localparam logic [2:0] OFS_PIN_FUNC = 3'h2;
    localparam logic [2:0] OFS_THRESHOLD = 3'h3;
    localparam logic [2:0] OFS_CORE_STATUS = 3'h4;

    // Field positions
    localparam int WDT_EN_BIT = 3;
    localparam int WDT_SEL_LSB = 0;
    localparam int FLAG_CTRL_CORRUPT_BIT = 3;
    localparam int FLAG_UNDERVOLT_BIT = 2;
    localparam int FLAG_THR_CORRUPT_BIT = 1;
    localparam int STAT_EXPIRY_BIT = 1;
    localparam int STAT_PDOWN_BIT = 0;

    // Values after reset and legal codes
    localparam logic [3:0] WDT_CTRL_RST = 4'hf;
    localparam logic [7:0] PIN_FUNC_IO = 8'h55;
    localparam logic [7:0] PIN_FUNC_EXT = 8'haa;
    localparam logic [7:0] THR_RST = 8'h55;
    localparam logic [7:0] THR_CODE_A = 8'h55;
    localparam logic [7:0] THR_CODE_B = 8'h33;
    localparam logic [7:0] THR_CODE_C = 8'h99;
    localparam logic [7:0] THR_CODE_D = 8'haa;
    localparam logic [7:0] THR_CODE_OFF = 8'hf0;

    // Watchdog counter: 8-bit prescale plus seven more stages
    localparam int WDT_CNT_W = 15;
    localparam int WDT_MIN_STAGES = 8;

    // Delays, in ns, and least cycle counts rounded up
    localparam int CORRUPT_DELAY_NS = 16000;
    localparam int RELEASE_DELAY_NS = 10000;
    localparam int CORRUPT_CYC = (CORRUPT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_CYC = (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W = 12;

    typedef enum logic [1:0] {
        SEQ_RUN = 2'b00,
        SEQ_HOLD = 2'b01,
        SEQ_RELEASE = 2'b10
    } wrc_seq_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wrc_bus_t;

    typedef struct packed {
        logic watchdog_clear_instruction;
        logic halt;
        logic asleep;
    } wrc_core_t;

endpackage

/* src/wrc_top.sv */
/*
 Watchdog timer and reset-source controller with its register file.
 Assumes the core drives watchdog_clear_instruction and halt as one-cycle pulses on clk_sys,
 the low-speed RC clock, clear pin and undervoltage detector arrive as
 asynchronous pins, and software is the only party on the register port.
*/
// Chosen here: the register offsets and the address-and-strobe port.
// What this block does
// - Watchdog counts only while its enable bit is one; no overflow otherwise.
// - Timeout select n gives a period of 2^(8+n) low-speed clock periods.
// - Overflow while running resets the device and sets the expiry flag.
// - Overflow while asleep sets expiry and power-down flags, clears only PC and SP.
// - The watchdog clear instruction zeroes the counter.
// - The power-down instruction also zeroes the counter.
// - Clear pin low, in reset function, zeroes the counter.
// - Power-on clears the program counter to zero.
// - Power-on sets port data and direction to all ones.
// - Clear pin reset leaves status flags unchanged.
// - After the clear pin is released, wait the release delay.
// - Clear pin low resets the device and restarts the program counter.
// - Pin function code 0x55 selects I/O, 0xaa selects clear pin.
// - Any other pin function code forces a full reset after a delay.
// - That corruption reset sets the control corruption flag.
// - Only a software write of zero clears the control corruption flag.
// - All resets but the warm watchdog reset restore pin function to 0x55.
// - Clear pin selection overrides every other sharing control of that pin.
// - A low-voltage reset is a full reset like the clear pin reset.
// - Reset flag bits 7 to 4 and bit 0 read as zero.
// - The watchdog counts edges of the low-speed RC clock.
// - Power-down instruction sets power-down flag and clears expiry flag.
// - Low-voltage reset sets the undervoltage flag; only software clears it.
// - An undefined threshold register value sets the threshold corruption flag.
`timescale 1ns/1ps
`default_nettype none

module wrc_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire wrc_pkg::wrc_bus_t bus,
    output logic [7:0] rdata,
    input wire wrc_pkg::wrc_core_t core,
    input wire logic low_speed_rc_clock,
    input wire logic external_clear_pin_n,
    input wire logic low_voltage_detect,
    output logic core_reset,
    output logic warm_reset,
    output logic pin_reset_select
);
    import wrc_pkg::*;

    // Lower 8+n bits set: 000 is the shortest, 111 the longest period
    function automatic logic [WDT_CNT_W-1:0] wdt_mask(input logic [2:0] sel);
        logic [WDT_CNT_W-1:0] m;
        m = {WDT_CNT_W{1'b1}} >> (3'd7 - sel);
        return m;
    endfunction

    function automatic logic thr_legal(input logic [7:0] v);
        return (v == THR_CODE_A) || (v == THR_CODE_B) || (v == THR_CODE_C) ||
            (v == THR_CODE_D) || (v == THR_CODE_OFF);
    endfunction

    // Pin synchronisers; stage one feeds stage two only
    logic [2:0] low_speed_rc_clock_sync_ff, nxt_low_speed_rc_clock_sync;
    logic [1:0] clr_sync_ff, nxt_clr_sync;
    logic [2:0] lv_sync_ff, nxt_lv_sync;

    always_comb begin
        nxt_low_speed_rc_clock_sync = {low_speed_rc_clock_sync_ff[1:0], low_speed_rc_clock};
        nxt_clr_sync = {clr_sync_ff[0], external_clear_pin_n};
        nxt_lv_sync = {lv_sync_ff[1:0], low_voltage_detect};
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            low_speed_rc_clock_sync_ff <= 3'h0;
            clr_sync_ff <= 2'h3;
            lv_sync_ff <= 3'h0;
        end else begin
            low_speed_rc_clock_sync_ff <= nxt_low_speed_rc_clock_sync;
            clr_sync_ff <= nxt_clr_sync;
            lv_sync_ff <= nxt_lv_sync;
        end
    end

    // Registers and flags
    logic wdt_en_ff, nxt_wdt_en;
    logic [2:0] wdt_sel_ff, nxt_wdt_sel;
    logic [7:0] pin_func_ff, nxt_pin_func;
    logic [7:0] thr_ff, nxt_thr;
    logic ctrl_corrupt_ff, nxt_ctrl_corrupt;
    logic undervolt_ff, nxt_undervolt;
    logic thr_corrupt_ff, nxt_thr_corrupt;
    logic expiry_ff, nxt_expiry;
    logic pdown_ff, nxt_pdown;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [WDT_CNT_W-1:0] wdt_cnt_ff, nxt_wdt_cnt;
    logic [DLY_W-1:0] corrupt_cnt_ff, nxt_corrupt_cnt;
    logic [DLY_W-1:0] release_cnt_ff, nxt_release_cnt;
    wrc_seq_t seq_ff, nxt_seq;
    logic core_reset_ff, nxt_core_reset;
    logic warm_reset_ff, nxt_warm_reset;

    // Event decode
    logic low_speed_rc_clock_tick, pin_reset_mode, ext_low, wdt_ovf, wdt_warm, wdt_cold;
    logic lvr_evt, pin_bad, thr_bad, corrupt_evt, cold_evt;

    always_comb begin
        low_speed_rc_clock_tick = low_speed_rc_clock_sync_ff[1] & ~low_speed_rc_clock_sync_ff[2];
        pin_reset_mode = (pin_func_ff == PIN_FUNC_EXT);
        ext_low = pin_reset_mode & ~clr_sync_ff[1];
        wdt_ovf = wdt_en_ff & low_speed_rc_clock_tick &&
            ((wdt_cnt_ff & wdt_mask(wdt_sel_ff)) == wdt_mask(wdt_sel_ff));
        wdt_warm = wdt_ovf & core.asleep;
        wdt_cold = wdt_ovf & ~core.asleep;
        // Detector is ignored while asleep, as the threshold circuit is off then
        lvr_evt = lv_sync_ff[1] & ~lv_sync_ff[2] & ~core.asleep;
        pin_bad = (pin_func_ff != PIN_FUNC_IO) && !pin_reset_mode;
        thr_bad = !thr_legal(thr_ff);
        corrupt_evt = (pin_bad | thr_bad) && (corrupt_cnt_ff == DLY_W'(CORRUPT_CYC - 1));
        cold_evt = wdt_cold | lvr_evt | corrupt_evt | ext_low;
    end

    // Watchdog counter and corruption delay
    always_comb begin
        nxt_wdt_cnt = wdt_cnt_ff;
        if (!wdt_en_ff) begin
            nxt_wdt_cnt = '0;
        end else if (core.watchdog_clear_instruction) begin
            nxt_wdt_cnt = '0;
        end else if (core.halt) begin
            nxt_wdt_cnt = '0;
        end else if (ext_low) begin
            nxt_wdt_cnt = '0;
        end else if (wdt_ovf || cold_evt) begin
            nxt_wdt_cnt = '0;
        end else if (low_speed_rc_clock_tick) begin
            nxt_wdt_cnt = wdt_cnt_ff + WDT_CNT_W'(1);
        end
        nxt_corrupt_cnt = '0;
        if ((pin_bad || thr_bad) && !corrupt_evt) begin
            nxt_corrupt_cnt = corrupt_cnt_ff + DLY_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdt_cnt_ff <= '0;
            corrupt_cnt_ff <= '0;
        end else begin
            wdt_cnt_ff <= nxt_wdt_cnt;
            corrupt_cnt_ff <= nxt_corrupt_cnt;
        end
    end

    // Register file; hardware sets win over software clears
    always_comb begin
        nxt_wdt_en = wdt_en_ff;
        nxt_wdt_sel = wdt_sel_ff;
        nxt_pin_func = pin_func_ff;
        nxt_thr = thr_ff;
        nxt_ctrl_corrupt = ctrl_corrupt_ff;
        nxt_undervolt = undervolt_ff;
        nxt_thr_corrupt = thr_corrupt_ff;
        nxt_expiry = expiry_ff;
        nxt_pdown = pdown_ff;
        if (bus.wr) begin
            case (bus.addr)
                OFS_WDT_CTRL: begin
                    nxt_wdt_en = bus.wdata[WDT_EN_BIT];
                    nxt_wdt_sel = bus.wdata[WDT_SEL_LSB +: 3];
                end
                OFS_RST_FLAGS: begin
                    // Flags only clear from software; writing one keeps them
                    nxt_ctrl_corrupt = ctrl_corrupt_ff & bus.wdata[FLAG_CTRL_CORRUPT_BIT];
                    nxt_undervolt = undervolt_ff & bus.wdata[FLAG_UNDERVOLT_BIT];
                    nxt_thr_corrupt = thr_corrupt_ff & bus.wdata[FLAG_THR_CORRUPT_BIT];
                end
                OFS_PIN_FUNC: begin
                    nxt_pin_func = bus.wdata;
                end
                OFS_THRESHOLD: begin
                    nxt_thr = bus.wdata;
                end
                default: begin
                end
            endcase
        end
        if (core.watchdog_clear_instruction) begin
            nxt_expiry = 1'b0;
            nxt_pdown = 1'b0;
        end
        if (core.halt) begin
            nxt_pdown = 1'b1;
            nxt_expiry = 1'b0;
        end
        // Restore on pin release; the pin keeps its reset role while held low
        if ((cold_evt || seq_ff == SEQ_HOLD) && !ext_low) begin
            nxt_wdt_en = WDT_CTRL_RST[WDT_EN_BIT];
            nxt_wdt_sel = WDT_CTRL_RST[WDT_SEL_LSB +: 3];
            nxt_pin_func = PIN_FUNC_IO;
            nxt_thr = THR_RST;
        end
        if (wdt_cold) begin
            nxt_expiry = 1'b1;
        end
        if (wdt_warm) begin
            nxt_expiry = 1'b1;
            nxt_pdown = 1'b1;
        end
        if (corrupt_evt && pin_bad) begin
            nxt_ctrl_corrupt = 1'b1;
        end
        if (lvr_evt) begin
            nxt_undervolt = 1'b1;
        end
        if (thr_bad) begin
            nxt_thr_corrupt = 1'b1;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                OFS_WDT_CTRL: nxt_rdata = {4'h0, wdt_en_ff, wdt_sel_ff};
                OFS_RST_FLAGS: nxt_rdata = {4'h0, ctrl_corrupt_ff, undervolt_ff,
                    thr_corrupt_ff, 1'b0};
                OFS_PIN_FUNC: nxt_rdata = pin_func_ff;
                OFS_THRESHOLD: nxt_rdata = thr_ff;
                OFS_CORE_STATUS: nxt_rdata = {6'h00, expiry_ff, pdown_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdt_en_ff <= WDT_CTRL_RST[WDT_EN_BIT];
            wdt_sel_ff <= WDT_CTRL_RST[WDT_SEL_LSB +: 3];
            pin_func_ff <= PIN_FUNC_IO;
            thr_ff <= THR_RST;
            ctrl_corrupt_ff <= 1'b0;
            undervolt_ff <= 1'b0;
            thr_corrupt_ff <= 1'b0;
            expiry_ff <= 1'b0;
            pdown_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            wdt_en_ff <= nxt_wdt_en;
            wdt_sel_ff <= nxt_wdt_sel;
            pin_func_ff <= nxt_pin_func;
            thr_ff <= nxt_thr;
            ctrl_corrupt_ff <= nxt_ctrl_corrupt;
            undervolt_ff <= nxt_undervolt;
            thr_corrupt_ff <= nxt_thr_corrupt;
            expiry_ff <= nxt_expiry;
            pdown_ff <= nxt_pdown;
            rdata_ff <= nxt_rdata;
        end
    end

    // Reset sequencer: hold while the pin is low, then the release delay
    always_comb begin
        nxt_seq = seq_ff;
        nxt_release_cnt = release_cnt_ff;
        case (seq_ff)
            SEQ_RUN: begin
                if (ext_low) begin
                    nxt_seq = SEQ_HOLD;
                end else if (wdt_cold || lvr_evt || corrupt_evt) begin
                    nxt_seq = SEQ_RELEASE;
                    nxt_release_cnt = '0;
                end
            end
            SEQ_HOLD: begin
                if (!ext_low) begin
                    nxt_seq = SEQ_RELEASE;
                    nxt_release_cnt = '0;
                end
            end
            SEQ_RELEASE: begin
                if (ext_low) begin
                    nxt_seq = SEQ_HOLD;
                end else if (release_cnt_ff == DLY_W'(RELEASE_CYC - 1)) begin
                    nxt_seq = SEQ_RUN;
                end else begin
                    nxt_release_cnt = release_cnt_ff + DLY_W'(1);
                end
            end
            default: begin
                nxt_seq = SEQ_RELEASE;
                nxt_release_cnt = '0;
            end
        endcase
        // Full reset clears PC and presets the ports to inputs
        nxt_core_reset = (nxt_seq != SEQ_RUN);
        nxt_warm_reset = wdt_warm && (seq_ff == SEQ_RUN);
    end

    // Power-on enters the release delay with the core held
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            seq_ff <= SEQ_RELEASE;
            release_cnt_ff <= '0;
            core_reset_ff <= 1'b1;
            warm_reset_ff <= 1'b0;
        end else begin
            seq_ff <= nxt_seq;
            release_cnt_ff <= nxt_release_cnt;
            core_reset_ff <= nxt_core_reset;
            warm_reset_ff <= nxt_warm_reset;
        end
    end

    assign rdata = rdata_ff;
    assign core_reset = core_reset_ff;
    assign warm_reset = warm_reset_ff;
    // Clear pin function overrides any other sharing of that pin
    assign pin_reset_select = pin_reset_mode;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    chk_wdt_off_zero: assert property (!wdt_en_ff |=> wdt_cnt_ff == '0)
        else $error("disabled watchdog counter not held at zero");
    chk_wdt_off_quiet: assert property (!wdt_en_ff && !expiry_ff |=> !expiry_ff && !warm_reset)
        else $error("overflow while watchdog disabled");
    chk_clr_insn: assert property (core.watchdog_clear_instruction && !wdt_ovf |=> wdt_cnt_ff == '0 && !expiry_ff)
        else $error("clear instruction did not zero watchdog");
    chk_halt_flags: assert property (core.halt && !wdt_ovf |=>
        wdt_cnt_ff == '0 && pdown_ff && !expiry_ff)
        else $error("halt did not clear watchdog or set power-down");
    chk_warm_flags: assert property (wdt_ovf && core.asleep && seq_ff == SEQ_RUN && !cold_evt |=>
        expiry_ff && pdown_ff && warm_reset && !core_reset)
        else $error("warm watchdog reset wrong");
    chk_cold_expiry: assert property (wdt_ovf && !core.asleep && !ext_low |=>
        expiry_ff && core_reset && pin_func_ff == PIN_FUNC_IO)
        else $error("watchdog overflow did not reset");
    chk_ext_hold: assert property (ext_low |=> core_reset && wdt_cnt_ff == '0)
        else $error("clear pin low did not hold reset");
    chk_release_wait: assert property ((seq_ff == SEQ_HOLD) ##1 (seq_ff == SEQ_RELEASE) |->
        core_reset[*8])
        else $error("release delay too short");
    chk_corrupt_flag: assert property (corrupt_evt && pin_bad |=>
        ctrl_corrupt_ff && core_reset && pin_func_ff == PIN_FUNC_IO)
        else $error("corruption reset wrong");
    chk_corrupt_sticky: assert property (ctrl_corrupt_ff &&
        !(bus.wr && bus.addr == OFS_RST_FLAGS) |=> ctrl_corrupt_ff)
        else $error("corruption flag cleared by hardware");
    chk_lvr_flag: assert property (lvr_evt |=> undervolt_ff && core_reset)
        else $error("low-voltage reset flag not set");
    chk_flags_zero: assert property (bus.rd && bus.addr == OFS_RST_FLAGS |=>
        rdata[7:4] == 4'h0 && !rdata[0])
        else $error("reserved flag bits not zero");
    chk_thr_flag: assert property (thr_bad |=> thr_corrupt_ff)
        else $error("threshold corruption flag not set");

endmodule

`default_nettype wire

/* bench/wrc_top_test.sv */
/*
 Self-checking bench for the watchdog and reset-source controller.
 Assumes the package constants as shipped (500-cycle release, 800-cycle
 corruption delay) and a bench-made slow clock of four system cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module wrc_top_test;
    import wrc_pkg::*;

    localparam int LIMIT = 60000;

    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    wrc_bus_t bus = '0;
    wrc_core_t core_in = '0;
    logic lsc = 1'b0;
    logic ext_n = 1'b1;
    logic lvd = 1'b0;
    logic [7:0] rdata;
    logic core_reset;
    logic warm_reset;
    logic pin_reset_select;
    logic div = 1'b0;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    wrc_top u_dut (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .bus(bus),
        .rdata(rdata),
        .core(core_in),
        .low_speed_rc_clock(lsc),
        .external_clear_pin_n(ext_n),
        .low_voltage_detect(lvd),
        .core_reset(core_reset),
        .warm_reset(warm_reset),
        .pin_reset_select(pin_reset_select)
    );

    always #10 clk_sys = ~clk_sys;

    // Slow clock far below the sync rate so no edge is lost
    always @(posedge clk_sys) begin
        div <= ~div;
        if (div) begin
            lsc <= ~lsc;
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        chk("read data", rdata, exp);
        @(posedge clk_sys);
        #1;
        chk("read data after", rdata, 8'h00);
    endtask

    task automatic core_pulse(input logic clr, input logic hlt);
        @(posedge clk_sys);
        core_in.watchdog_clear_instruction <= clr;
        core_in.halt <= hlt;
        @(posedge clk_sys);
        core_in.watchdog_clear_instruction <= 1'b0;
        core_in.halt <= 1'b0;
    endtask

    task automatic wait_level(input logic lvl, input int lim, output int n);
        n = 0;
        while (core_reset !== lvl && n < lim) begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end
    endtask

    task automatic range(input string name, input int n, input int lo, input int hi);
        chk(name, {7'h00, (n >= lo && n <= hi)}, 8'h01);
    endtask

    int n;
    int per;
    logic [7:0] v;
    logic [7:0] rst_val [6] = '{8'h0f, 8'h00, 8'h55, 8'h55, 8'h00, 8'h00};
    logic [7:0] thr_codes [5] = '{THR_CODE_A, THR_CODE_B, THR_CODE_C, THR_CODE_D, THR_CODE_OFF};

    initial begin
        void'($urandom(69853));
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("core reset after power-on", {7'h00, core_reset}, 8'h01);
        wait_level(1'b0, 600, n);
        range("release delay", n, RELEASE_CYC - 3, RELEASE_CYC + 3);
        for (int a = 0; a < 6; a++) begin
            rd(a[2:0], rst_val[a]);
        end
        wr(OFS_RST_FLAGS, 8'hff);
        rd(OFS_RST_FLAGS, 8'h00);
        wr(OFS_WDT_CTRL, 8'hf0);
        rd(OFS_WDT_CTRL, 8'h00);
        // Disabled: well past the shortest period, no reset
        wait_level(1'b1, 1500, n);
        chk("disabled no reset", n[7:0], 8'hdc);
        wr(OFS_WDT_CTRL, 8'h08);
        for (int i = 0; i < 4; i++) begin
            core_pulse(1'b1, 1'b0);
            wait_level(1'b1, 400 + ($urandom % 300), n);
            chk("cleared no reset", {7'h00, core_reset}, 8'h00);
        end
        // Period for select codes 0 to 2, counted from a clear
        for (int s = 0; s < 3; s++) begin
            wr(OFS_WDT_CTRL, 8'h08 | s[7:0]);
            core_pulse(1'b1, 1'b0);
            per = (1 << (8 + s)) * 4;
            wait_level(1'b1, per + 40, n);
            range("timeout period", n, per - (1 << s) * 4 - 8, per + 16);
            wait_level(1'b0, 600, n);
            rd(OFS_CORE_STATUS, 8'h02);
            rd(OFS_WDT_CTRL, 8'h0f);
        end
        // Warm reset from sleep keeps registers
        wr(OFS_PIN_FUNC, PIN_FUNC_EXT);
        wr(OFS_WDT_CTRL, 8'h08);
        core_pulse(1'b0, 1'b1);
        rd(OFS_CORE_STATUS, 8'h01);
        core_in.asleep <= 1'b1;
        n = 0;
        while (warm_reset !== 1'b1 && n < 1200) begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end
        range("halt clears count", n, 1024 - 60, 1024 + 30);
        chk("no full reset asleep", {7'h00, core_reset}, 8'h00);
        @(posedge clk_sys);
        #1;
        chk("warm pulse length", {7'h00, warm_reset}, 8'h00);
        core_in.asleep <= 1'b0;
        wr(OFS_WDT_CTRL, 8'h00);
        rd(OFS_CORE_STATUS, 8'h03);
        rd(OFS_PIN_FUNC, PIN_FUNC_EXT);
        chk("pin select", {7'h00, pin_reset_select}, 8'h01);
        // Clear pin in its reset function
        ext_n <= 1'b0;
        wait_level(1'b1, 10, n);
        range("clear pin reset", n, 1, 6);
        repeat (20) @(posedge clk_sys);
        ext_n <= 1'b1;
        wait_level(1'b0, 600, n);
        range("clear pin release", n, RELEASE_CYC, RELEASE_CYC + 8);
        rd(OFS_CORE_STATUS, 8'h03);
        rd(OFS_PIN_FUNC, PIN_FUNC_IO);
        chk("pin select io", {7'h00, pin_reset_select}, 8'h00);
        ext_n <= 1'b0;
        wait_level(1'b1, 30, n);
        chk("pin as io no reset", n[7:0], 8'h1e);
        ext_n <= 1'b1;
        // Corrupted pin function code
        v = PIN_FUNC_IO;
        while (v == PIN_FUNC_IO || v == PIN_FUNC_EXT) begin
            v = 8'($urandom);
        end
        wr(OFS_PIN_FUNC, v);
        wait_level(1'b1, 1000, n);
        range("corruption delay", n, CORRUPT_CYC - 10, CORRUPT_CYC + 10);
        wait_level(1'b0, 600, n);
        rd(OFS_RST_FLAGS, 8'h08);
        rd(OFS_PIN_FUNC, PIN_FUNC_IO);
        wr(OFS_RST_FLAGS, 8'hff);
        rd(OFS_RST_FLAGS, 8'h08);
        wr(OFS_RST_FLAGS, 8'h00);
        rd(OFS_RST_FLAGS, 8'h00);
        // Low-voltage event
        lvd <= 1'b1;
        wait_level(1'b1, 10, n);
        range("low voltage reset", n, 1, 6);
        lvd <= 1'b0;
        wait_level(1'b0, 600, n);
        rd(OFS_RST_FLAGS, 8'h04);
        wr(OFS_RST_FLAGS, 8'h00);
        rd(OFS_RST_FLAGS, 8'h00);
        // Threshold codes: legal ones stay quiet
        for (int i = 0; i < 5; i++) begin
            wr(OFS_THRESHOLD, thr_codes[i]);
            rd(OFS_THRESHOLD, thr_codes[i]);
            rd(OFS_RST_FLAGS, 8'h00);
        end
        wr(OFS_THRESHOLD, 8'h12);
        rd(OFS_RST_FLAGS, 8'h02);
        wait_level(1'b1, 1000, n);
        wait_level(1'b0, 600, n);
        rd(OFS_THRESHOLD, THR_RST);
        summarize();
    end

endmodule

`default_nettype wire
